// ===== design/drl_pkg.sv
// Shared constants and helpers for the dual-rail line and data link taps
// Functional notes
// - Tx rail inputs sampled on tx clock falling edge, replacing encoder bits.
// - After reset the external tx rail inputs feed line pulses while the direction bit is clear.
// - Tx pair 00 none, 01 negative, 10 positive, 11 invalid and never driven.
// - Tx rail outputs change on tx clock output rising edge, high per polarity.
// - Link input sampled on gapped clock falling edge during selected bits, inserted.
// - Tx gapped clock is high in low half of tx clock, selected bits only.
// - Tx clock output is selected input or all-ones clock, else attenuated clock.
// - Tx NRZ output changes on tx clock rising edge, without encoder violations.
// - Multiframe mark high one tx clock cycle at first multiframe bit, rising edge.
// - Rx clock input used only in dual-rail digital input mode, else ignored.
// - Rx rail inputs sampled on rx clock input falling edge in that mode.
// - Rx pair 00 none, 01 negative, 10 positive, 11 invalid.
// - Single-rail NRZ accepted on either rx rail with the other grounded.
// - Rx clock output is recovered clock or attenuated clock per selection.
// - Rx rail outputs change on rx clock output rising edge, high per polarity.
// - Rx link output carries all data as NRZ, changing on rx clock falling edge.
// - Rx gapped clock high in low half of rx clock, selected bits, else low.
`default_nettype none

package drl_pkg;

  // Rail pair codes, positive rail in bit 1
  localparam logic [1:0] RAIL_NONE = 2'h0;
  localparam logic [1:0] RAIL_NEG = 2'h1;
  localparam logic [1:0] RAIL_POS = 2'h2;
  localparam logic [1:0] RAIL_BAD = 2'h3;

  // Positions of the outside pins in the synchroniser bundle
  localparam int PIN_COUNT = 12;
  localparam int PIN_TX_CLK = 0;
  localparam int PIN_ACK_CLK = 1;
  localparam int PIN_JAT_CLK = 2;
  localparam int PIN_RX_CLK = 3;
  localparam int PIN_RCV_CLK = 4;
  localparam int PIN_TX_POS = 5;
  localparam int PIN_TX_NEG = 6;
  localparam int PIN_TX_LINK = 7;
  localparam int PIN_RX_POS = 8;
  localparam int PIN_RX_NEG = 9;
  localparam int PIN_LINE_POS = 10;
  localparam int PIN_LINE_NEG = 11;

  // Timing: own clock and the fastest link clock the sampler must follow
  localparam int MCLK_PERIOD_NS = 10;
  localparam int LINK_CLK_PERIOD_NS = 80;
  localparam int LINK_CLK_CYCLES = LINK_CLK_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // Reset values
  localparam logic RST_LEVEL = 1'b0;
  localparam logic [1:0] RST_RAILS = RAIL_NONE;
  localparam logic [2:0] RST_SYNC = 3'h0;

  // Any pulse, including the invalid pair, counts as a mark
  function automatic logic railMark(input logic [1:0] pair);
    return pair != RAIL_NONE;
  endfunction : railMark

  // Both rails high at once
  function automatic logic railBad(input logic [1:0] pair);
    return pair == RAIL_BAD;
  endfunction : railBad

endpackage : drl_pkg

`default_nettype wire

// ===== design/drl_pin_sync.sv
// Two-stage synchroniser with edge detection for one outside pin
`default_nettype none

module drl_pin_sync
  import drl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw pin
  input wire logic pinRaw,
  // Synchronised level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic [2:0] stages;
  logic [2:0] next_stages;

  // Shift in; stage 0 feeds only stage 1, edges compare stages 1 and 2
  always_comb begin
    next_stages = {stages[1:0], pinRaw};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stages <= RST_SYNC;
    end else begin
      stages <= next_stages;
    end
  end

  assign level = stages[1];
  assign rise = stages[1] & ~stages[2];
  assign fall = ~stages[1] & stages[2];

endmodule : drl_pin_sync

`default_nettype wire

// ===== design/drl_taps.sv
// Dual-rail line taps and gapped data link clocks of the transceiver
`default_nettype none

module drl_taps
  import drl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,

  // Transmit clock pins
  input wire logic txLineClkIn,
  input wire logic allOnesClkIn,
  input wire logic jitterAttenuatedClk,

  // Transmit rail and link pins
  input wire logic txPosRailIn,
  input wire logic txNegRailIn,
  input wire logic txLinkDataIn,

  // Transmit configuration
  input wire logic txLinkDirectionBit,
  input wire logic txJitterAttenuatorEn,
  input wire logic allOnesClkSelect,

  // Internal transmitter feed
  input wire logic encPos,
  input wire logic encNeg,
  input wire logic txNrzData,
  input wire logic txMultiframeStart,
  input wire logic txSlotSelect,

  // Transmit outputs
  output logic txLineClkOut,
  output logic txPosRailOut,
  output logic txNegRailOut,
  output logic txLinkGappedClk,
  output logic txNrzOut,
  output logic txMultiframeMark,

  // Transmit status to the framer
  output logic txLinkBit,
  output logic txLinkBitStrobe,
  output logic txRailInvalid,

  // Receive pins
  input wire logic rxLineClkIn,
  input wire logic rxPosRailIn,
  input wire logic rxNegRailIn,
  input wire logic recoveredLineClk,
  input wire logic rxLinePosIn,
  input wire logic rxLineNegIn,

  // Receive configuration
  input wire logic rxDigitalInputSelect,
  input wire logic rxJatClkSelect,
  input wire logic rxSlotSelect,

  // Receive outputs
  output logic rxLineClkOut,
  output logic rxPosRailOut,
  output logic rxNegRailOut,
  output logic rxLinkDataOut,
  output logic rxLinkGappedClk,
  output logic rxRailInvalid
);

  // Pin bundle through the synchronisers
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinLevel;
  logic [PIN_COUNT-1:0] pinRise;
  logic [PIN_COUNT-1:0] pinFall;

  assign pinRaw[PIN_TX_CLK] = txLineClkIn;
  assign pinRaw[PIN_ACK_CLK] = allOnesClkIn;
  assign pinRaw[PIN_JAT_CLK] = jitterAttenuatedClk;
  assign pinRaw[PIN_RX_CLK] = rxLineClkIn;
  assign pinRaw[PIN_RCV_CLK] = recoveredLineClk;
  assign pinRaw[PIN_TX_POS] = txPosRailIn;
  assign pinRaw[PIN_TX_NEG] = txNegRailIn;
  assign pinRaw[PIN_TX_LINK] = txLinkDataIn;
  assign pinRaw[PIN_RX_POS] = rxPosRailIn;
  assign pinRaw[PIN_RX_NEG] = rxNegRailIn;
  assign pinRaw[PIN_LINE_POS] = rxLinePosIn;
  assign pinRaw[PIN_LINE_NEG] = rxLineNegIn;

  // Every pin is outside our clock, so each passes two flip-flops first.
  // Data and clock pins share the same latency, keeping their alignment.
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    drl_pin_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .pinRaw(pinRaw[i]),
      .level(pinLevel[i]),
      .rise(pinRise[i]),
      .fall(pinFall[i])
    );
  end

  // ---------------- Transmit side ----------------

  logic txSrcLevel;
  logic txSrcRise;
  logic txSrcFall;
  logic txClkOutNext;
  logic txClkOutRise;

  // Selected source clock; a switch mid-cycle may clip one bit
  assign txSrcLevel = allOnesClkSelect ? pinLevel[PIN_ACK_CLK] : pinLevel[PIN_TX_CLK];
  assign txSrcRise = allOnesClkSelect ? pinRise[PIN_ACK_CLK] : pinRise[PIN_TX_CLK];
  assign txSrcFall = allOnesClkSelect ? pinFall[PIN_ACK_CLK] : pinFall[PIN_TX_CLK];

  assign txClkOutNext = txJitterAttenuatorEn ? pinLevel[PIN_JAT_CLK] : txSrcLevel;
  assign txClkOutRise = txClkOutNext & ~txLineClkOut;

  logic txSrcInternal;
  logic [1:0] txCapture;
  logic [1:0] txRails;
  logic next_txSrcInternal;
  logic [1:0] next_txCapture;
  logic [1:0] next_txRails;
  logic next_txLineClkOut;
  logic next_txLinkGappedClk;
  logic next_txNrzOut;
  logic next_txMultiframeMark;
  logic next_txLinkBit;
  logic next_txLinkBitStrobe;
  logic next_txRailInvalid;

  // Transmit next-state logic
  always_comb begin
    logic [1:0] pair;
    pair = RAIL_NONE;
    // external rails until software flips the direction bit
    next_txSrcInternal = txLinkDirectionBit;
    next_txLineClkOut = txClkOutNext;
    next_txCapture = txCapture;
    next_txRails = txRails;
    next_txLinkGappedClk = txLinkGappedClk;
    next_txNrzOut = txNrzOut;
    next_txMultiframeMark = txMultiframeMark;
    next_txLinkBit = txLinkBit;
    next_txLinkBitStrobe = 1'b0;
    next_txRailInvalid = 1'b0;

    if (txSrcFall) begin
      next_txCapture = {pinLevel[PIN_TX_POS], pinLevel[PIN_TX_NEG]};
      // gapped pulse opens for the low half
      next_txLinkGappedClk = txSlotSelect;
    end

    if (txSrcRise) begin
      // gapped pulse closes with the high half
      next_txLinkGappedClk = 1'b0;
      // gapped clock falls now, so take the link bit
      if (txLinkGappedClk) begin
        next_txLinkBit = pinLevel[PIN_TX_LINK];
        next_txLinkBitStrobe = 1'b1;
      end
      // NRZ carries framer data, no encoder violations
      // link bits take the place of selected positions
      next_txNrzOut = txLinkGappedClk ? pinLevel[PIN_TX_LINK] : txNrzData;
      // one-cycle mark aligned with the NRZ bit
      next_txMultiframeMark = txMultiframeStart;
    end

    if (txClkOutRise) begin
      // rails launched on tx clock output rise
      pair = txSrcInternal ? {encPos, encNeg} : txCapture;
      // both-ones is never put on the line
      if (railBad(pair)) begin
        next_txRails = RAIL_NONE;
        next_txRailInvalid = 1'b1;
      end else begin
        next_txRails = pair;
      end
    end
  end

  // Transmit registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      txSrcInternal <= RST_LEVEL;
      txLineClkOut <= RST_LEVEL;
      txCapture <= RST_RAILS;
      txRails <= RST_RAILS;
      txLinkGappedClk <= RST_LEVEL;
      txNrzOut <= RST_LEVEL;
      txMultiframeMark <= RST_LEVEL;
      txLinkBit <= RST_LEVEL;
      txLinkBitStrobe <= RST_LEVEL;
      txRailInvalid <= RST_LEVEL;
    end else begin
      txSrcInternal <= next_txSrcInternal;
      txLineClkOut <= next_txLineClkOut;
      txCapture <= next_txCapture;
      txRails <= next_txRails;
      txLinkGappedClk <= next_txLinkGappedClk;
      txNrzOut <= next_txNrzOut;
      txMultiframeMark <= next_txMultiframeMark;
      txLinkBit <= next_txLinkBit;
      txLinkBitStrobe <= next_txLinkBitStrobe;
      txRailInvalid <= next_txRailInvalid;
    end
  end

  assign txPosRailOut = txRails[1];
  assign txNegRailOut = txRails[0];

  // ---------------- Receive side ----------------

  logic rxClkOutNext;
  logic rxClkOutRise;
  logic rxClkOutFall;

  assign rxClkOutNext = rxJatClkSelect ? pinLevel[PIN_JAT_CLK] : pinLevel[PIN_RCV_CLK];
  assign rxClkOutRise = rxClkOutNext & ~rxLineClkOut;
  assign rxClkOutFall = ~rxClkOutNext & rxLineClkOut;

  logic rxDigital;
  logic [1:0] rxCapture;
  logic [1:0] rxRails;
  logic next_rxDigital;
  logic [1:0] next_rxCapture;
  logic [1:0] next_rxRails;
  logic next_rxLineClkOut;
  logic next_rxLinkDataOut;
  logic next_rxLinkGappedClk;
  logic next_rxRailInvalid;

  // Receive next-state logic
  always_comb begin
    next_rxDigital = rxDigitalInputSelect;
    next_rxLineClkOut = rxClkOutNext;
    next_rxCapture = rxCapture;
    next_rxRails = rxRails;
    next_rxLinkDataOut = rxLinkDataOut;
    next_rxLinkGappedClk = rxLinkGappedClk;
    next_rxRailInvalid = 1'b0;

    // rx clock pin only matters in digital mode
    if (rxDigital) begin
      // single-rail NRZ passes as one-sided pulses
      if (pinFall[PIN_RX_CLK]) begin
        next_rxCapture = {pinLevel[PIN_RX_POS], pinLevel[PIN_RX_NEG]};
      end
    end else if (pinRise[PIN_RCV_CLK]) begin
      // Analog path slicer output, timed by the recovered clock
      next_rxCapture = {pinLevel[PIN_LINE_POS], pinLevel[PIN_LINE_NEG]};
    end

    if (rxClkOutRise) begin
      // decode pair; invalid drives neither polarity
      // rails launched on rx clock output rise
      next_rxRails = railBad(rxCapture) ? RAIL_NONE : rxCapture;
      next_rxRailInvalid = railBad(rxCapture);
      // gapped pulse closes with the high half
      next_rxLinkGappedClk = 1'b0;
    end

    if (rxClkOutFall) begin
      // every bit as NRZ, not only selected ones
      // invalid pair still yields a mark
      next_rxLinkDataOut = railMark(rxCapture);
      // gapped pulse only on selected bits
      next_rxLinkGappedClk = rxSlotSelect;
    end
  end

  // Receive registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxDigital <= RST_LEVEL;
      rxLineClkOut <= RST_LEVEL;
      rxCapture <= RST_RAILS;
      rxRails <= RST_RAILS;
      rxLinkDataOut <= RST_LEVEL;
      rxLinkGappedClk <= RST_LEVEL;
      rxRailInvalid <= RST_LEVEL;
    end else begin
      rxDigital <= next_rxDigital;
      rxLineClkOut <= next_rxLineClkOut;
      rxCapture <= next_rxCapture;
      rxRails <= next_rxRails;
      rxLinkDataOut <= next_rxLinkDataOut;
      rxLinkGappedClk <= next_rxLinkGappedClk;
      rxRailInvalid <= next_rxRailInvalid;
    end
  end

  assign rxPosRailOut = rxRails[1];
  assign rxNegRailOut = rxRails[0];

endmodule : drl_taps

`default_nettype wire

// ===== test/drl_assertions.sv
// Concurrent checks on the tap outputs, bound into drl_taps
`default_nettype none

module drl_checker
  import drl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Slot markers
  input wire logic txSlotSelect,
  input wire logic rxSlotSelect,
  // Watched outputs
  input wire logic txPosRailOut,
  input wire logic txNegRailOut,
  input wire logic rxPosRailOut,
  input wire logic rxNegRailOut,
  input wire logic txLinkGappedClk,
  input wire logic rxLinkGappedClk,
  input wire logic txLinkBitStrobe,
  input wire logic txRailInvalid,
  input wire logic txMultiframeMark
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Half a line clock is four mclk, so a gapped pulse spans four cycles
  sequence halfHigh(s);
    s[*3] ##[1:3] !s;
  endsequence
  // A whole line clock is eight mclk
  sequence fullHigh(s);
    s[*7] ##[1:3] !s;
  endsequence

  tx_rail_excl_a: assert property (!(txPosRailOut && txNegRailOut))
    else $error("tx rails both high");
  rx_rail_excl_a: assert property (!(rxPosRailOut && rxNegRailOut))
    else $error("rx rails both high");
  tx_gap_slot_a: assert property ($rose(txLinkGappedClk) |-> $past(txSlotSelect))
    else $error("tx gapped clock outside slot");
  rx_gap_slot_a: assert property ($rose(rxLinkGappedClk) |-> $past(rxSlotSelect))
    else $error("rx gapped clock outside slot");
  tx_gap_width_a: assert property ($rose(txLinkGappedClk) |-> halfHigh(txLinkGappedClk))
    else $error("tx gapped pulse width");
  rx_gap_width_a: assert property ($rose(rxLinkGappedClk) |-> halfHigh(rxLinkGappedClk))
    else $error("rx gapped pulse width");
  strobe_cause_a: assert property ($rose(txLinkBitStrobe) |-> $fell(txLinkGappedClk))
    else $error("link bit taken off gapped edge");
  mark_width_a: assert property ($rose(txMultiframeMark) |-> fullHigh(txMultiframeMark))
    else $error("multiframe mark width");
  tx_inv_pulse_a: assert property (txRailInvalid |=> !txRailInvalid)
    else $error("invalid pulse too long");
endmodule : drl_checker

bind drl_taps drl_checker u_chk (.mclk, .rst, .txSlotSelect, .rxSlotSelect,
  .txPosRailOut, .txNegRailOut, .rxPosRailOut, .rxNegRailOut, .txLinkGappedClk,
  .rxLinkGappedClk, .txLinkBitStrobe, .txRailInvalid, .txMultiframeMark);

`default_nettype wire

// ===== test/drl_liu_model.sv
// Line interface model: line clock and rail pairs toward the taps
`default_nettype none

module drl_liu_model
  import drl_pkg::*;
(
  // Control from the bench
  input wire logic en,
  input wire logic [1:0] txPair,
  input wire logic [1:0] rxPair,
  // Line side pins
  output logic lclk,
  output logic [1:0] txRail,
  output logic [1:0] rxRail
);
  timeunit 1ns;
  timeprecision 100ps;

  // 80 ns line clock, still outside frames, phase offset from mclk
  initial begin
    lclk = 1'b0;
    #43;
    forever #40 lclk = en ? ~lclk : 1'b0;
  end
  // pairs only as asked while enabled
  // Rails move just after the rise so the falling edge sees them settled;
  // released rails show the inverse of the last value, not a stale copy
  initial begin
    txRail = RAIL_NONE;
    rxRail = RAIL_NONE;
    forever begin
      @(posedge lclk or negedge en);
      if (en) begin
        #1;
        txRail = txPair;
        rxRail = rxPair;
      end else begin
        txRail = ~txRail;
        rxRail = ~rxRail;
      end
    end
  end
endmodule : drl_liu_model

`default_nettype wire

// ===== test/drl_taps_test.sv
// Self-checking bench for the dual-rail taps
`default_nettype none

module drl_taps_test
  import drl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, en, txLinkDirectionBit, txJitterAttenuatorEn, allOnesClkSelect;
  logic encPos, encNeg, txNrzData, txMultiframeStart, txSlotSelect, txLinkDataIn;
  logic rxLinePosIn, rxLineNegIn, rxDigitalInputSelect, rxJatClkSelect, rxSlotSelect;
  logic txLineClkOut, txPosRailOut, txNegRailOut, txLinkGappedClk, txNrzOut;
  logic txMultiframeMark, rxLineClkOut, rxPosRailOut, rxNegRailOut, rxLinkDataOut;
  logic rxLinkGappedClk, txLinkBit, txLinkBitStrobe, txRailInvalid, rxRailInvalid, altEn;
  logic [1:0] txP, rxP;
  wire logic lclk;
  wire logic mainClk, altClk;
  wire logic [1:0] txR, rxR;
  int failures, tests_run;
  int pulses[3];

  // Line clock steered to the main or the alternate clock pins; the idle one stays low,
  // so a wrong clock choice stalls the outputs and shows up in the checks
  assign mainClk = lclk & ~altEn;
  assign altClk = lclk & altEn;

  // Count one-cycle status pulses so a bit check can still see them later
  always @(posedge mclk) begin
    if (txLinkBitStrobe === 1'b1) pulses[0] <= pulses[0] + 1;
    if (txRailInvalid === 1'b1) pulses[1] <= pulses[1] + 1;
    if (rxRailInvalid === 1'b1) pulses[2] <= pulses[2] + 1;
  end

  // Far side and the block under test
  drl_liu_model u_liu (.en, .txPair(txP), .rxPair(rxP), .lclk, .txRail(txR), .rxRail(rxR));
  drl_taps u_dut (.mclk, .rst, .txLineClkIn(mainClk), .allOnesClkIn(altClk),
    .jitterAttenuatedClk(altClk), .txPosRailIn(txR[1]), .txNegRailIn(txR[0]), .txLinkDataIn,
    .txLinkDirectionBit, .txJitterAttenuatorEn, .allOnesClkSelect, .encPos, .encNeg,
    .txNrzData, .txMultiframeStart, .txSlotSelect, .txLineClkOut, .txPosRailOut,
    .txNegRailOut, .txLinkGappedClk, .txNrzOut, .txMultiframeMark, .txLinkBit,
    .txLinkBitStrobe, .txRailInvalid, .rxLineClkIn(lclk), .rxPosRailIn(rxR[1]),
    .rxNegRailIn(rxR[0]), .recoveredLineClk(mainClk), .rxLinePosIn, .rxLineNegIn,
    .rxDigitalInputSelect, .rxJatClkSelect, .rxSlotSelect, .rxLineClkOut, .rxPosRailOut,
    .rxNegRailOut, .rxLinkDataOut, .rxLinkGappedClk, .rxRailInvalid);

  // Print counts and the verdict, then stop
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Compare one observed pair against its expectation
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check

  // Bounded wait for a line clock level; a lost clock ends the run
  task automatic waitLvl(input logic v);
    int n;
    for (n = 0; n < 12 && lclk !== v; n++) @(negedge mclk);
    if (lclk !== v) begin
      failures++;
      give_verdict();
    end
  endtask : waitLvl

  // One line bit: pair before the rise, slot after it, link data after the fall
  task automatic sendBit(input logic [1:0] tp, rp, input logic sl, ln, nz, mf);
    logic [1:0] eTx;
    logic [1:0] eRx;
    int base[3];
    eTx = txLinkDirectionBit ? {encPos, encNeg} : (tp == RAIL_BAD ? RAIL_NONE : tp);
    eRx = rxDigitalInputSelect ? (rp == RAIL_BAD ? RAIL_NONE : rp) : {rxLinePosIn, rxLineNegIn};
    waitLvl(1);
    waitLvl(0);
    txP = tp;
    rxP = rp;
    waitLvl(1);
    txSlotSelect = sl;
    rxSlotSelect = sl;
    waitLvl(0);
    txLinkDataIn = ln;
    txNrzData = nz;
    txMultiframeStart = mf;
    // Synced edges land 15 ns after the level is seen and stand some 40 ns
    repeat (3) @(negedge mclk);
    check({txLinkGappedClk, rxLinkGappedClk}, {sl, sl});
    base = pulses;
    waitLvl(1);
    repeat (3) @(negedge mclk);
    check({txLineClkOut, rxLineClkOut}, 2'h3);
    check({txPosRailOut, txNegRailOut}, eTx);
    check({txNrzOut, txMultiframeMark}, {sl ? ln : nz, mf});
    check({rxPosRailOut, rxNegRailOut}, eRx);
    check(2'(pulses[0] - base[0]), {1'b0, sl});
    check(2'(pulses[1] - base[1]), {1'b0, tp == RAIL_BAD && !txLinkDirectionBit});
    check(2'(pulses[2] - base[2]), {1'b0, rp == RAIL_BAD && rxDigitalInputSelect});
    if (sl) check({1'b0, txLinkBit}, {1'b0, ln});
    txMultiframeStart = 1'b0;
    waitLvl(0);
    repeat (3) @(negedge mclk);
    check({rxLinkDataOut, rxLinkGappedClk},
      {(rxDigitalInputSelect ? rp : {rxLinePosIn, rxLineNegIn}) != RAIL_NONE, sl});
  endtask : sendBit

  // 100 MHz own clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    {en, txLinkDirectionBit, txJitterAttenuatorEn, allOnesClkSelect, encPos, encNeg} = '0;
    {txNrzData, txMultiframeStart, txSlotSelect, txLinkDataIn, rxLinePosIn} = '0;
    {rxLineNegIn, rxJatClkSelect, rxSlotSelect, txP, rxP, failures, tests_run, altEn} = '0;
    rxDigitalInputSelect = 1'b1;
    rst = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    en = 1'b1;
    // Every tx and rx pair code, slots alternating, one multiframe start
    for (int i = 0; i < 4; i++) sendBit(2'(i), 2'(3 - i), i[0], ~i[1], i[1], i == 2);
    // Internal rails and the other clock choices; external 11 must be ignored
    {txLinkDirectionBit, txJitterAttenuatorEn, allOnesClkSelect, rxJatClkSelect, altEn} = 5'h1F;
    for (int j = 1; j < 3; j++) begin
      {encPos, encNeg} = 2'(j);
      sendBit(RAIL_BAD, RAIL_NEG, 1'b1, 1'b1, 1'b0, 1'b0);
    end
    // Analog path: digital rails and their clock pin carry no weight
    {txLinkDirectionBit, txJitterAttenuatorEn, allOnesClkSelect, rxJatClkSelect, altEn} = 5'h0;
    rxDigitalInputSelect = 1'b0;
    {rxLinePosIn, rxLineNegIn} = RAIL_NEG;
    sendBit(RAIL_POS, RAIL_NONE, 1'b0, 1'b0, 1'b1, 1'b0);
    en = 1'b0;
    repeat (20) @(negedge mclk);
    give_verdict();
  end
endmodule : drl_taps_test

`default_nettype wire
